// [logic/dcb_lane_cmp.sv]
/*
  One lane comparator: equal, less-than or less-or-equal, signed or unsigned.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module dcb_lane_cmp #(
  parameter int unsigned W = 8
) (
  // Operands
  input  wire logic            [W-1:0] a_i,
  input  wire logic            [W-1:0] b_i,
  // Mode
  input  wire logic                    signed_i,
  input  wire dcb_pkg::dcb_cmp_op_type op_i,
  // Result
  output logic                         result_o
);

  // Flipping the top bit turns a signed order into an unsigned one
  wire logic [W-1:0] a_ord = {a_i[W-1] ^ signed_i, a_i[W-2:0]};
  wire logic [W-1:0] b_ord = {b_i[W-1] ^ signed_i, b_i[W-2:0]};
  wire logic         eq    = (a_ord == b_ord);
  wire logic         lt    = (a_ord < b_ord);

  always_comb begin
    case (op_i)
      dcb_pkg::CMP_EQ: result_o = eq;
      dcb_pkg::CMP_LT: result_o = lt;
      dcb_pkg::CMP_LE: result_o = lt | eq;
      default:         result_o = 1'b0;
    endcase
  end

endmodule : dcb_lane_cmp

// [logic/dcb_pkg.sv]
/*
  Constants and types shared by the compare/branch unit and its lane comparator.
  Assumes a 32-bit instruction word and 32-bit general-purpose operands.
*/
package dcb_pkg;

  // Instruction fields
  localparam int unsigned MAJOR_HI     = 31;
  localparam int unsigned MAJOR_LO     = 26;
  localparam int unsigned SUB_HI       = 25;
  localparam int unsigned SUB_LO       = 21;
  localparam int unsigned ZERO5_HI     = 20;
  localparam int unsigned ZERO5_LO     = 16;
  localparam int unsigned OFFSET_HI    = 15;
  localparam int unsigned RD_HI        = 15;
  localparam int unsigned RD_LO        = 11;
  localparam int unsigned RSV_BIT      = 10;
  localparam int unsigned MINOR_HI     = 9;
  localparam int unsigned HALF_ZERO_HI = 15;
  localparam int unsigned HALF_ZERO_LO = 10;

  // Major codes
  localparam logic [5:0] MAJOR_GROUP_A   = 6'h00;
  localparam logic [5:0] IMMEDIATE_GROUP = 6'h10;
  localparam logic [5:0] MAJOR_GROUP_S   = 6'h16;

  // Position-branch sub code
  localparam logic [4:0] BRANCH_SUB = 5'h1b;
  localparam logic [4:0] ZERO5      = 5'h00;
  localparam logic [5:0] ZERO6      = 6'h00;

  // Minor codes
  localparam logic [9:0] HALF_EQ = 10'h005;
  localparam logic [9:0] HALF_LT = 10'h045;
  localparam logic [9:0] HALF_LE = 10'h085;
  localparam logic [9:0] GPR_EQ  = 10'h0c5;
  localparam logic [9:0] GPR_LT  = 10'h105;
  localparam logic [9:0] GPR_LE  = 10'h145;
  localparam logic [9:0] DUAL_EQ = 10'h185;
  localparam logic [9:0] DUAL_LT = 10'h1c5;
  localparam logic [9:0] DUAL_LE = 10'h205;

  // Bit-position limit for the branch
  localparam logic [5:0] POS_LIMIT = 6'h20;

  // Widths
  localparam int unsigned WORD_W  = 32;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned HALF_W  = 16;
  localparam int unsigned CC_W    = 4;
  localparam int unsigned OFF_W   = 16;

  typedef enum logic [1:0] {
    CMP_EQ = 2'h0,
    CMP_LT = 2'h1,
    CMP_LE = 2'h2
  } dcb_cmp_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_SLOT = 2'h2
  } dcb_state_type;

endpackage : dcb_pkg

// [logic/dcb_unit.sv]
/*
  Compare and position-branch execution unit for the DSP extension.
  Assumes the pipeline presents one decoded instruction per valid_i cycle,
  with operands, the address of the next instruction and the control fields,
  all on clk_sys_i; results appear one cycle later on registered outputs.
*/
`timescale 1ns/1ps
module dcb_unit (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Issued instruction
  input  wire logic        valid_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] pc_next_i,
  input  wire logic [31:0] source_reg_a_i,
  input  wire logic [31:0] source_reg_b_i,
  // Control register fields
  input  wire logic        dsp_enable_i,
  input  wire logic [5:0]  dsp_pos_i,
  input  wire logic [3:0]  dsp_cc_i,
  // Branch decision
  output logic             br_valid_o,
  output logic             br_taken_o,
  output logic [31:0]      br_target_o,
  output logic             redirect_valid_o,
  output logic [31:0]      redirect_target_o,
  // Results
  output logic             gpr_we_o,
  output logic [4:0]       gpr_rd_o,
  output logic [31:0]      gpr_data_o,
  output logic             cc_we_o,
  output logic [3:0]       cc_o,
  // Exceptions
  output logic             exc_reserved_o,
  output logic             exc_dsp_disabled_o
);

  localparam int unsigned NB = dcb_pkg::WORD_W / dcb_pkg::BYTE_W;
  localparam int unsigned NH = dcb_pkg::WORD_W / dcb_pkg::HALF_W;

  function automatic dcb_pkg::dcb_cmp_op_type op_of(input logic [9:0] m,
                                                    input logic [9:0] eq_code,
                                                    input logic [9:0] lt_code);
    if (m == eq_code) begin
      return dcb_pkg::CMP_EQ;
    end else if (m == lt_code) begin
      return dcb_pkg::CMP_LT;
    end
    return dcb_pkg::CMP_LE;
  endfunction : op_of

  function automatic logic is_code(input logic [9:0] m, input logic [9:0] c0,
                                   input logic [9:0] c1, input logic [9:0] c2);
    return (m == c0) || (m == c1) || (m == c2);
  endfunction : is_code

  // Field decode
  wire logic [5:0] major = instr_i[dcb_pkg::MAJOR_HI:dcb_pkg::MAJOR_LO];
  wire logic [9:0] minor = instr_i[dcb_pkg::MINOR_HI:0];
  wire logic       rsv_ok = (instr_i[dcb_pkg::RSV_BIT] == 1'b0);

  wire logic is_branch = (major == dcb_pkg::IMMEDIATE_GROUP)
                       && (instr_i[dcb_pkg::SUB_HI:dcb_pkg::SUB_LO] == dcb_pkg::BRANCH_SUB)
                       && (instr_i[dcb_pkg::ZERO5_HI:dcb_pkg::ZERO5_LO]
                           == dcb_pkg::ZERO5);
  wire logic is_half = (major == dcb_pkg::MAJOR_GROUP_A)
                     && (instr_i[dcb_pkg::HALF_ZERO_HI:dcb_pkg::HALF_ZERO_LO]
                         == dcb_pkg::ZERO6)
                     && is_code(minor, dcb_pkg::HALF_EQ, dcb_pkg::HALF_LT,
                                dcb_pkg::HALF_LE);
  wire logic is_gpr = (major == dcb_pkg::MAJOR_GROUP_S) && rsv_ok
                    && is_code(minor, dcb_pkg::GPR_EQ, dcb_pkg::GPR_LT,
                               dcb_pkg::GPR_LE);
  wire logic is_dual = (major == dcb_pkg::MAJOR_GROUP_A) && rsv_ok
                     && is_code(minor, dcb_pkg::DUAL_EQ, dcb_pkg::DUAL_LT,
                                dcb_pkg::DUAL_LE);

  wire logic hit = valid_i && (is_branch || is_half || is_gpr || is_dual);
  wire logic go  = hit && dsp_enable_i;

  wire dcb_pkg::dcb_cmp_op_type half_op = op_of(minor, dcb_pkg::HALF_EQ, dcb_pkg::HALF_LT);
  wire dcb_pkg::dcb_cmp_op_type byte_op = is_dual
                                        ? op_of(minor, dcb_pkg::DUAL_EQ, dcb_pkg::DUAL_LT)
                                        : op_of(minor, dcb_pkg::GPR_EQ, dcb_pkg::GPR_LT);

  // Lanes
  logic [NB-1:0] byte_res;
  logic [NH-1:0] half_res;

  for (genvar i = 0; i < NB; i++) begin : g_byte
    dcb_lane_cmp #(.W(dcb_pkg::BYTE_W)) u_lane (
      .a_i      (source_reg_a_i[i*dcb_pkg::BYTE_W +: dcb_pkg::BYTE_W]),
      .b_i      (source_reg_b_i[i*dcb_pkg::BYTE_W +: dcb_pkg::BYTE_W]),
      .signed_i (1'b0),
      .op_i     (byte_op),
      .result_o (byte_res[i])
    );
  end

  for (genvar i = 0; i < NH; i++) begin : g_half
    dcb_lane_cmp #(.W(dcb_pkg::HALF_W)) u_lane (
      .a_i      (source_reg_a_i[i*dcb_pkg::HALF_W +: dcb_pkg::HALF_W]),
      .b_i      (source_reg_b_i[i*dcb_pkg::HALF_W +: dcb_pkg::HALF_W]),
      .signed_i (1'b1),
      .op_i     (half_op),
      .result_o (half_res[i])
    );
  end

  // Branch arithmetic
  wire logic [31:0] off_ext = {{(dcb_pkg::WORD_W - dcb_pkg::OFF_W - 1){instr_i[dcb_pkg::OFFSET_HI]}},
                               instr_i[dcb_pkg::OFFSET_HI:0], 1'b0};
  wire logic [31:0] next_target = pc_next_i + off_ext;
  wire logic        next_taken  = (dsp_pos_i >= dcb_pkg::POS_LIMIT);

  // On halfword compares the upper condition bits are kept as they were; that choice is cheapest
  wire logic [3:0] next_cc = is_half ? {dsp_cc_i[3:2], half_res} : byte_res;
  wire logic [31:0] next_gpr = {{(dcb_pkg::WORD_W - dcb_pkg::CC_W){1'b0}}, byte_res};

  // Delay-slot tracking
  dcb_pkg::dcb_state_type state;
  dcb_pkg::dcb_state_type next_state;
  logic                   pend_taken;
  logic [31:0]            pend_target;

  wire logic arm     = (state == dcb_pkg::ST_IDLE) && go && is_branch;
  wire logic slot_ex = (state == dcb_pkg::ST_SLOT) && valid_i;

  always_comb begin
    case (state)
      dcb_pkg::ST_IDLE: next_state = arm ? dcb_pkg::ST_SLOT : dcb_pkg::ST_IDLE;
      dcb_pkg::ST_SLOT: next_state = valid_i ? dcb_pkg::ST_IDLE : dcb_pkg::ST_SLOT;
      default:          next_state = dcb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state       <= dcb_pkg::ST_IDLE;
      pend_taken  <= 1'b0;
      pend_target <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (arm) begin
        pend_taken  <= next_taken;
        pend_target <= next_target;
      end
    end
  end

  // Redirect only after the slot instruction issues; not taken falls through
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      redirect_valid_o  <= 1'b0;
      redirect_target_o <= 32'h0000_0000;
    end else begin
      redirect_valid_o  <= slot_ex && pend_taken;
      redirect_target_o <= pend_target;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      br_valid_o  <= 1'b0;
      br_taken_o  <= 1'b0;
      br_target_o <= 32'h0000_0000;
    end else begin
      br_valid_o  <= go && is_branch;
      br_taken_o  <= go && is_branch && next_taken;
      br_target_o <= next_target;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      gpr_we_o   <= 1'b0;
      gpr_rd_o   <= 5'h00;
      gpr_data_o <= 32'h0000_0000;
      cc_we_o    <= 1'b0;
      cc_o       <= 4'h0;
    end else begin
      gpr_we_o   <= go && (is_gpr || is_dual);
      gpr_rd_o   <= instr_i[dcb_pkg::RD_HI:dcb_pkg::RD_LO];
      gpr_data_o <= next_gpr;
      cc_we_o    <= go && (is_half || is_dual);
      cc_o       <= next_cc;
    end
  end

  // Exceptions come from decode and enable only, never from operand data
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      exc_reserved_o     <= 1'b0;
      exc_dsp_disabled_o <= 1'b0;
    end else begin
      exc_reserved_o     <= valid_i && !hit;
      exc_dsp_disabled_o <= hit && !dsp_enable_i;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_branch_decode: assert property (
    valid_i && dsp_enable_i && is_branch |=> br_valid_o && !exc_reserved_o)
    else $error("branch not recognised");

  chk_branch_target: assert property (
    br_valid_o |-> br_target_o == $past(pc_next_i)
      + {{15{$past(instr_i[15])}}, $past(instr_i[15:0]), 1'b0})
    else $error("branch target wrong");

  chk_branch_taken: assert property (
    br_valid_o |-> br_taken_o == ($past(dsp_pos_i) >= 6'h20))
    else $error("branch decision wrong");

  chk_branch_exc: assert property (
    valid_i && is_branch && !dsp_enable_i |=> exc_dsp_disabled_o && !br_valid_o
      && !exc_reserved_o)
    else $error("branch exception wrong");

  chk_half_lanes: assert property (
    valid_i && dsp_enable_i && is_half && minor == 10'h005
    |=> cc_we_o && !gpr_we_o
      && cc_o[1] == ($past(source_reg_a_i[31:16]) == $past(source_reg_b_i[31:16]))
      && cc_o[0] == ($past(source_reg_a_i[15:0]) == $past(source_reg_b_i[15:0])))
    else $error("halfword result wrong");

  chk_half_signed: assert property (
    valid_i && dsp_enable_i && is_half && minor == 10'h045
    |=> cc_o[0] == ($signed($past(source_reg_a_i[15:0]))
                    < $signed($past(source_reg_b_i[15:0]))))
    else $error("halfword less-than wrong");

  chk_half_keep: assert property (
    valid_i && dsp_enable_i && is_half |=> cc_o[3:2] == $past(dsp_cc_i[3:2]))
    else $error("upper condition bits disturbed");

  chk_gpr_zero: assert property (
    gpr_we_o |-> gpr_data_o[31:4] == 28'h000_0000)
    else $error("upper result bits not zero");

  chk_byte_unsigned: assert property (
    valid_i && dsp_enable_i && is_gpr && minor == 10'h105
    |=> gpr_data_o[3] == ($past(source_reg_a_i[31:24]) < $past(source_reg_b_i[31:24]))
     && !cc_we_o)
    else $error("byte less-than wrong");

  chk_dual_both: assert property (
    valid_i && dsp_enable_i && is_dual |=> gpr_we_o && cc_we_o && cc_o == gpr_data_o[3:0])
    else $error("dual destinations differ");

  chk_no_data_exc: assert property (
    valid_i && dsp_enable_i && (is_half || is_gpr || is_dual)
    |=> !exc_reserved_o && !exc_dsp_disabled_o)
    else $error("compare raised exception");

  chk_slot_redirect: assert property (
    br_valid_o ##1 (valid_i && state == dcb_pkg::ST_SLOT)
    |=> redirect_valid_o == $past(br_taken_o, 2))
    else $error("delay slot redirect wrong");

  chk_slot_next: assert property (
    br_valid_o && valid_i && state == dcb_pkg::ST_SLOT
    |=> redirect_valid_o == $past(br_taken_o))
    else $error("back-to-back slot redirect wrong");

  chk_slot_wait: assert property (
    br_valid_o && !valid_i |=> !redirect_valid_o)
    else $error("redirect before delay slot");

  chk_dual_lanes: assert property (
    valid_i && dsp_enable_i && is_dual && minor == 10'h1c5
    |=> cc_o[3] == ($past(source_reg_a_i[31:24]) < $past(source_reg_b_i[31:24]))
     && cc_o[0] == ($past(source_reg_a_i[7:0]) < $past(source_reg_b_i[7:0])))
    else $error("dual lane order wrong");

  chk_byte_le: assert property (
    valid_i && dsp_enable_i && is_gpr && minor == 10'h145
    |=> gpr_data_o[1] == ($past(source_reg_a_i[15:8]) <= $past(source_reg_b_i[15:8])))
    else $error("byte less-or-equal wrong");

  chk_reserved_alone: assert property (
    exc_reserved_o |-> !br_valid_o && !gpr_we_o && !cc_we_o
      && !exc_dsp_disabled_o)
    else $error("reserved exception not alone");

  chk_gpr_index: assert property (
    valid_i && dsp_enable_i && is_gpr |=> gpr_rd_o == $past(instr_i[15:11]))
    else $error("destination index wrong");

  cov_taken: cover property (br_valid_o && br_taken_o ##[1:20] redirect_valid_o);
  cov_not_taken: cover property (br_valid_o && !br_taken_o);
  cov_dual: cover property (gpr_we_o && cc_we_o);
  cov_disabled: cover property (exc_dsp_disabled_o);

endmodule : dcb_unit

// [verification/dcb_pipe_model.sv]
/*
  Pipeline model: presents one decoded instruction per issue call to the unit.
  Assumes the caller stands at a falling edge of clk_i when it calls a task.
*/
`timescale 1ns/1ps
module dcb_pipe_model (
  // Clock
  input  wire logic        clk_i,
  // Issue side
  output logic             valid_o,
  output logic [31:0]      instr_o,
  output logic [31:0]      pc_next_o,
  output logic [31:0]      op_a_o,
  output logic [31:0]      op_b_o,
  // Control register fields
  output logic             en_o,
  output logic [5:0]       pos_o,
  output logic [3:0]       cc_o
);
  initial begin
    valid_o   = 1'h0;
    instr_o   = 32'h0000_0000;
    pc_next_o = 32'h0001_2000;
    op_a_o    = 32'h0000_0000;
    op_b_o    = 32'h0000_0000;
    en_o      = 1'h1;
    pos_o     = 6'h00;
    cc_o      = 4'hc;
  end

  // One instruction held for one full cycle, taken at the rising edge between
  task automatic issue(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                       input logic en, input logic [5:0] pos);
    valid_o = 1'h1;
    instr_o = ins;
    op_a_o  = a;
    op_b_o  = b;
    en_o    = en;
    pos_o   = pos;
    @(negedge clk_i);
  endtask : issue

  // Idle cycle: operands and condition bits turn over so stale values never look meaningful
  task automatic idle();
    valid_o = 1'h0;
    cc_o    = ~cc_o;
    instr_o = ~instr_o;
    op_a_o  = ~op_a_o;
    op_b_o  = ~op_b_o;
    @(negedge clk_i);
  endtask : idle
endmodule : dcb_pipe_model

// [verification/tb_dcb_unit.sv]
/*
  Self-checking bench for the compare and position-branch unit.
  Assumes the pipeline model drives every issue input; bench owns clock and reset.
*/
`timescale 1ns/1ps
module tb_dcb_unit;
  typedef struct packed {
    logic [31:0] ins;
    logic [31:0] a;
    logic [31:0] b;
    logic        en;
    logic [3:0]  fl;
    logic [3:0]  gpr;
    logic [3:0]  cc;
  } dcb_row_type;
  localparam logic [5:0]  GA = dcb_pkg::MAJOR_GROUP_A;
  localparam logic [5:0]  GS = dcb_pkg::MAJOR_GROUP_S;
  localparam logic [31:0] HA = 32'h8000_0005;
  localparam logic [31:0] HB = 32'h7fff_0005;
  localparam logic [31:0] QA = 32'h0180_ff10;
  localparam logic [31:0] QB = 32'h0280_0010;
  logic        clk_sys_i = 1'h0;
  logic        rst_i     = 1'h1;
  logic        valid_i, dsp_enable_i;
  logic [31:0] instr_i, pc_next_i, source_reg_a_i, source_reg_b_i;
  logic [5:0]  dsp_pos_i;
  logic [3:0]  dsp_cc_i;
  logic        br_valid_o, br_taken_o, redirect_valid_o, gpr_we_o, cc_we_o;
  logic        exc_reserved_o, exc_dsp_disabled_o;
  logic [31:0] br_target_o, redirect_target_o, gpr_data_o;
  logic [4:0]  gpr_rd_o;
  logic [3:0]  cc_o;
  int          err_total  = 0;
  int          num_checks = 0;
  dcb_row_type rows [15];
  logic [15:0] offs [3] = '{16'h7fff, 16'h8000, 16'h0001};
  logic [31:0] tgts [3] = '{32'h0002_1ffe, 32'h0000_2000, 32'h0001_2002};
  logic [5:0]  poss [3] = '{6'h1f, 6'h20, 6'h3f};

  always #5 clk_sys_i = ~clk_sys_i;

  dcb_pipe_model pipe_u (.clk_i(clk_sys_i), .valid_o(valid_i), .instr_o(instr_i),
    .pc_next_o(pc_next_i), .op_a_o(source_reg_a_i), .op_b_o(source_reg_b_i),
    .en_o(dsp_enable_i), .pos_o(dsp_pos_i), .cc_o(dsp_cc_i));

  dcb_unit dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .valid_i(valid_i),
    .instr_i(instr_i), .pc_next_i(pc_next_i), .source_reg_a_i(source_reg_a_i),
    .source_reg_b_i(source_reg_b_i), .dsp_enable_i(dsp_enable_i), .dsp_pos_i(dsp_pos_i),
    .dsp_cc_i(dsp_cc_i), .br_valid_o(br_valid_o), .br_taken_o(br_taken_o),
    .br_target_o(br_target_o), .redirect_valid_o(redirect_valid_o),
    .redirect_target_o(redirect_target_o), .gpr_we_o(gpr_we_o), .gpr_rd_o(gpr_rd_o),
    .gpr_data_o(gpr_data_o), .cc_we_o(cc_we_o), .cc_o(cc_o),
    .exc_reserved_o(exc_reserved_o), .exc_dsp_disabled_o(exc_dsp_disabled_o));

  function automatic logic [31:0] mk(input logic [5:0] maj, input logic [4:0] rd,
                                     input logic [9:0] mn);
    return {maj, 10'h000, rd, 1'h0, mn};
  endfunction : mk

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Whole run is well under 100 cycles; this margin only catches a hang
  initial begin
    #20000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    // Flags are {gpr_we, cc_we, exc_reserved, exc_dsp_disabled}
    rows = '{
      '{mk(GA, 5'h00, dcb_pkg::HALF_EQ), HA, HB, 1'h1, 4'h4, 4'h0, 4'hd},
      '{mk(GA, 5'h00, dcb_pkg::HALF_LT), HA, HB, 1'h1, 4'h4, 4'h0, 4'he},
      '{mk(GA, 5'h00, dcb_pkg::HALF_LE), HA, HB, 1'h1, 4'h4, 4'h0, 4'hf},
      '{mk(GS, 5'h1d, dcb_pkg::GPR_EQ), QA, QB, 1'h1, 4'h8, 4'h5, 4'h0},
      '{mk(GS, 5'h1d, dcb_pkg::GPR_LT), QA, QB, 1'h1, 4'h8, 4'h8, 4'h0},
      '{mk(GS, 5'h1d, dcb_pkg::GPR_LE), QA, QB, 1'h1, 4'h8, 4'hd, 4'h0},
      '{mk(GA, 5'h1d, dcb_pkg::DUAL_EQ), QA, QB, 1'h1, 4'hc, 4'h5, 4'h5},
      '{mk(GA, 5'h1d, dcb_pkg::DUAL_LT), QA, QB, 1'h1, 4'hc, 4'h8, 4'h8},
      '{mk(GA, 5'h1d, dcb_pkg::DUAL_LE), QA, QB, 1'h1, 4'hc, 4'hd, 4'hd},
      '{32'hffff_ffff, QA, QB, 1'h1, 4'h2, 4'h0, 4'h0},
      '{mk(GS, 5'h1d, dcb_pkg::GPR_EQ) | 32'h0000_0400, QA, QB, 1'h1, 4'h2, 4'h0, 4'h0},
      '{mk(GA, 5'h01, dcb_pkg::HALF_EQ), HA, HB, 1'h1, 4'h2, 4'h0, 4'h0},
      '{mk(GS, 5'h1d, dcb_pkg::GPR_EQ), QA, QB, 1'h0, 4'h1, 4'h0, 4'h0},
      '{32'h4361_0000, QA, QB, 1'h1, 4'h2, 4'h0, 4'h0},
      '{32'h4360_0000, QA, QB, 1'h0, 4'h1, 4'h0, 4'h0}};
    repeat (4) @(negedge clk_sys_i);
    chk({br_valid_o, redirect_valid_o, gpr_we_o, cc_we_o, exc_reserved_o,
         exc_dsp_disabled_o}, 32'h0000_0000);
    rst_i = 1'h0;
    @(negedge clk_sys_i);
    $display("test reset done");
    // Rows run back to back, one instruction per cycle
    foreach (rows[i]) begin
      pipe_u.issue(rows[i].ins, rows[i].a, rows[i].b, rows[i].en, 6'h00);
      chk(gpr_we_o, rows[i].fl[3]);
      if (rows[i].fl[3]) chk(gpr_data_o, {28'h000_0000, rows[i].gpr});
      if (rows[i].fl[3]) chk(gpr_rd_o, 5'h1d);
      chk(cc_we_o, rows[i].fl[2]);
      if (rows[i].fl[2]) chk(cc_o, rows[i].cc);
      chk(exc_reserved_o, rows[i].fl[1]);
      chk(exc_dsp_disabled_o, rows[i].fl[0]);
      chk(br_valid_o, 1'h0);
    end
    $display("test table done");
    // Branch at the limit boundary, with both extreme offsets and offset 1, each followed by its slot
    foreach (poss[i]) begin
      pipe_u.idle();
      pipe_u.issue({16'h4360, offs[i]}, QA, QB, 1'h1, poss[i]);
      chk(br_valid_o, 1'h1);
      chk(br_taken_o, poss[i] >= 6'h20);
      chk(br_target_o, tgts[i]);
      chk(exc_reserved_o | exc_dsp_disabled_o, 1'h0);
      chk(redirect_valid_o, 1'h0);
      // One taken branch waits an idle cycle before its slot
      if (i == 1) begin
        pipe_u.idle();
        chk(redirect_valid_o, 1'h0);
      end
      pipe_u.issue(mk(GS, 5'h1d, dcb_pkg::GPR_EQ), QA, QB, 1'h1, poss[i]);
      chk(gpr_we_o, 1'h1);
      chk(redirect_valid_o, poss[i] >= 6'h20);
      if (poss[i] >= 6'h20) chk(redirect_target_o, tgts[i]);
    end
    $display("test branch done");
    // Reset in mid-run clears the result already registered on the outputs the cycle before
    pipe_u.issue(mk(GS, 5'h1d, dcb_pkg::GPR_EQ), QA, QB, 1'h1, 6'h00);
    rst_i = 1'h1;
    pipe_u.idle();
    chk({gpr_we_o, cc_we_o, br_valid_o, redirect_valid_o}, 32'h0000_0000);
    rst_i = 1'h0;
    pipe_u.idle();
    pipe_u.idle();
    pipe_u.issue(mk(GA, 5'h00, dcb_pkg::HALF_EQ), HA, HB, 1'h1, 6'h00);
    chk(cc_we_o, 1'h1);
    chk(cc_o, {dsp_cc_i[3:2], 2'h1});
    chk(gpr_we_o | exc_reserved_o | exc_dsp_disabled_o, 1'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb_dcb_unit
